// [rtl/limiter_clipper_fault_status.sv]
// output limiter, clipper, fault status and two-wire register slave
//
// Function
// - limiter threshold from field, default full scale
// - attack and release rates programmed independently
// - threshold compared after volume gain
// - onset time is attack rate times excess
// - release reduction gradually at release rate
// - symmetric digital clip below full scale
// - clip level field, default clips only the most negative code
// - flag overcurrent, temperature, undervoltage, clock, port
// - flags for clipping and active limiting
// - output short sets overcurrent, drivers off
// - status flags stay set, read only
// - writing one to clear resets flags
// - overtemperature warning follows its condition
// - slew control bit selects low emission
// - idle outputs mid rail, rare pulses
// - idle differential pulses kept minimal width
// - pulse density and width follow level
// - load setting field drives power stage
// - slave only on two-wire bus
// - address byte: seven bits then direction
// - address low bits from strap pin
// - limiter off until enable bit set
// - status readable at status register
`timescale 1ns/1ps
`include "lcfs_defs.svh"
module limiter_clipper_fault_status #(
    parameter logic [31:0] ATTACK_UNIT_CYCLES  = 32'(`ATTACK_UNIT_CYC),
    parameter logic [31:0] RELEASE_UNIT_CYCLES = 32'(`RELEASE_UNIT_CYC)
) (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    // two-wire control port
    input  wire logic              i_scl,
    input  wire logic              i_sda_in,
    output logic                   o_sda_out,
    output logic                   o_sda_oe,
    // address strap, synchronised and taken as the two low address bits
    input  wire logic [1:0]        i_addr_sel,
    // samples after volume control
    input  wire lcfs_pkg::sample_t i_sample,
    input  wire logic              i_sample_valid,
    // analogue fault detectors
    input  wire logic              i_short_det,
    input  wire logic              i_overtemp,
    input  wire logic              i_overtemp_warn,
    input  wire logic              i_undervolt,
    // serial port monitors
    input  wire logic              i_clk_ratio_err,
    input  wire logic              i_serial_err,
    // processed samples
    output lcfs_pkg::sample_t      o_sample,
    output logic                   o_sample_valid,
    // power stage
    output logic                   o_out_pos,
    output logic                   o_out_neg,
    output logic                   o_drv_en,
    output logic                   o_low_emi,
    output logic [1:0]             o_load_setting,
    output logic                   o_low_power
);
    logic [1:0] rst_pipe_reg;
    wire        rst_n = rst_pipe_reg[1];

    // reset release through two flops
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end

    // pin synchronisers
    logic [3:0] pin_s;
    logic [3:0] flt_s;
    bit_sync #(.WIDTH(4), .RST_VAL(4'h3)) u_pin_sync (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_async ({i_addr_sel, i_scl, i_sda_in}),
        .o_sync  (pin_s)
    );
    bit_sync #(.WIDTH(4), .RST_VAL(4'h0)) u_flt_sync (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_async ({i_short_det, i_overtemp, i_overtemp_warn, i_undervolt}),
        .o_sync  (flt_s)
    );
    wire scl_s  = pin_s[1];
    wire sda_s  = pin_s[0];
    wire ocp_s  = flt_s[3];
    wire otf_s  = flt_s[2];
    wire otw_s  = flt_s[1];
    wire uvlo_s = flt_s[0];

    // strap capture once the synchroniser has settled
    logic [1:0] strap_cnt_reg;
    logic [1:0] addr_lo_reg;
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_reg <= 2'h0;
            addr_lo_reg   <= 2'h0;
        end else if (strap_cnt_reg != 2'h3) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            addr_lo_reg   <= pin_s[3:2];
        end
    end
    wire [6:0] dev_addr = {`I2C_ADDR_HI, addr_lo_reg};

    // bus edge and condition detection
    logic scl_d_reg;
    logic sda_d_reg;
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end
    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    wire start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // register file
    logic [7:0] pwr_ctrl_reg;
    logic [7:0] clip_reg;
    logic [7:0] amp_output_control_reg;
    logic [7:0] lim_ctrl_reg;
    logic [7:0] lim_thr_reg;
    logic [7:0] status_reg;
    logic       wr_stb_reg;
    logic [7:0] wr_addr_reg;
    logic [7:0] wr_data_reg;
    logic [7:0] ptr_reg;
    wire  [7:0] rdata;

    // read selection
    assign rdata = (ptr_reg == `REG_PWR_CTRL) ? pwr_ctrl_reg :
                   (ptr_reg == `REG_CLIP)     ? clip_reg :
                   (ptr_reg == `REG_AMP_CTRL) ? amp_output_control_reg :
                   (ptr_reg == `REG_LIM_CTRL) ? lim_ctrl_reg :
                   (ptr_reg == `REG_LIM_THR)  ? lim_thr_reg :
                   (ptr_reg == `REG_STATUS)   ? status_reg : 8'h00;

    // two-wire slave: answers only, never starts a transfer
    lcfs_pkg::i2c_state_t state_reg;
    logic [3:0] cnt_reg;
    logic [7:0] sh_reg;
    logic       rw_reg;
    logic       oe_reg;
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= lcfs_pkg::I2C_IDLE;
            cnt_reg     <= 4'h0;
            sh_reg      <= 8'h00;
            ptr_reg     <= 8'h00;
            rw_reg      <= 1'b0;
            oe_reg      <= 1'b0;
            wr_stb_reg  <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
        end else begin
            wr_stb_reg <= 1'b0;
            if (stop_c) begin
                state_reg <= lcfs_pkg::I2C_IDLE;
                oe_reg    <= 1'b0;
            end else if (start_c) begin
                state_reg <= lcfs_pkg::I2C_ADDR;
                cnt_reg   <= 4'h0;
                oe_reg    <= 1'b0;
            end else if (scl_rise) begin
                case (state_reg)
                    lcfs_pkg::I2C_ADDR, lcfs_pkg::I2C_SUB, lcfs_pkg::I2C_WDATA: begin
                        if (cnt_reg != 4'h8) begin
                            sh_reg  <= {sh_reg[6:0], sda_s};
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    end
                    lcfs_pkg::I2C_RACK: begin
                        if (sda_s) begin
                            state_reg <= lcfs_pkg::I2C_IDLE; // master nack ends read
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (state_reg)
                    lcfs_pkg::I2C_ADDR: begin
                        if (cnt_reg == 4'h8) begin
                            cnt_reg <= 4'h0;
                            if (sh_reg[7:1] == dev_addr) begin
                                rw_reg    <= sh_reg[0];
                                oe_reg    <= 1'b1;
                                state_reg <= lcfs_pkg::I2C_ADDR_ACK;
                            end else begin
                                state_reg <= lcfs_pkg::I2C_IDLE;
                            end
                        end
                    end
                    lcfs_pkg::I2C_SUB: begin
                        if (cnt_reg == 4'h8) begin
                            cnt_reg <= 4'h0;
                            if (sh_reg <= `REG_MAX) begin
                                ptr_reg   <= sh_reg;
                                oe_reg    <= 1'b1;
                                state_reg <= lcfs_pkg::I2C_SUB_ACK;
                            end else begin
                                state_reg <= lcfs_pkg::I2C_IDLE; // bad subaddress, no ack
                            end
                        end
                    end
                    lcfs_pkg::I2C_WDATA: begin
                        if (cnt_reg == 4'h8) begin
                            cnt_reg <= 4'h0;
                            if (ptr_reg <= `REG_MAX) begin
                                wr_stb_reg  <= 1'b1;
                                wr_addr_reg <= ptr_reg;
                                wr_data_reg <= sh_reg;
                                ptr_reg     <= ptr_reg + 8'h01;
                                oe_reg      <= 1'b1;
                                state_reg   <= lcfs_pkg::I2C_WACK;
                            end else begin
                                state_reg <= lcfs_pkg::I2C_IDLE; // past top, no ack
                            end
                        end
                    end
                    lcfs_pkg::I2C_ADDR_ACK: begin
                        if (rw_reg) begin
                            sh_reg    <= rdata;
                            oe_reg    <= ~rdata[7];
                            cnt_reg   <= 4'h1;
                            state_reg <= lcfs_pkg::I2C_RDATA;
                        end else begin
                            oe_reg    <= 1'b0;
                            state_reg <= lcfs_pkg::I2C_SUB;
                        end
                    end
                    lcfs_pkg::I2C_SUB_ACK, lcfs_pkg::I2C_WACK: begin
                        oe_reg    <= 1'b0;
                        state_reg <= lcfs_pkg::I2C_WDATA;
                    end
                    lcfs_pkg::I2C_RDATA: begin
                        if (cnt_reg == 4'h8) begin
                            oe_reg    <= 1'b0;
                            state_reg <= lcfs_pkg::I2C_RACK;
                            if (ptr_reg < `REG_MAX) begin
                                ptr_reg <= ptr_reg + 8'h01; // top register repeats
                            end
                        end else begin
                            oe_reg  <= ~sh_reg[6];
                            sh_reg  <= {sh_reg[6:0], 1'b0};
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    end
                    lcfs_pkg::I2C_RACK: begin
                        sh_reg    <= rdata;
                        oe_reg    <= ~rdata[7];
                        cnt_reg   <= 4'h1;
                        state_reg <= lcfs_pkg::I2C_RDATA;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // write decode
    wire wr_pwr  = wr_stb_reg & (wr_addr_reg == `REG_PWR_CTRL);
    wire wr_clip = wr_stb_reg & (wr_addr_reg == `REG_CLIP);
    wire wr_amp  = wr_stb_reg & (wr_addr_reg == `REG_AMP_CTRL);
    wire wr_lim  = wr_stb_reg & (wr_addr_reg == `REG_LIM_CTRL);
    wire wr_thr  = wr_stb_reg & (wr_addr_reg == `REG_LIM_THR);
    wire st_clr  = wr_stb_reg & (wr_addr_reg == `REG_STAT_CLR) & wr_data_reg[`STAT_CLR_BIT];

    // control registers, reserved bits held at zero
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_ctrl_reg           <= `PWR_CTRL_RST;
            clip_reg               <= `CLIP_RST;
            amp_output_control_reg <= `AMP_CTRL_RST;
            lim_ctrl_reg           <= `LIM_CTRL_RST;
            lim_thr_reg            <= `LIM_THR_RST;
        end else begin
            if (wr_pwr)  pwr_ctrl_reg           <= wr_data_reg & `PWR_CTRL_MASK;
            if (wr_clip) clip_reg               <= wr_data_reg;
            if (wr_amp)  amp_output_control_reg <= wr_data_reg & `AMP_CTRL_MASK;
            if (wr_lim)  lim_ctrl_reg           <= wr_data_reg & `LIM_CTRL_MASK;
            if (wr_thr)  lim_thr_reg            <= wr_data_reg & `LIM_THR_MASK;
        end
    end
    wire       limiter_enable_bit  = pwr_ctrl_reg[`PWR_LIMITER_ENABLE_BIT_BIT];
    wire       shdn    = pwr_ctrl_reg[`PWR_SHDN_BIT];
    wire [1:0] atr     = lim_ctrl_reg[`LIMITER_ATTACK_RATE_FIELD_MSB:`LIMITER_ATTACK_RATE_FIELD_LSB];
    wire [1:0] rrt     = lim_ctrl_reg[`LIMITER_RELEASE_RATE_FIELD_MSB:`LIMITER_RELEASE_RATE_FIELD_LSB];
    wire [4:0] thr     = lim_thr_reg[`THR_MSB:0];

    // limiter level detection on the post-volume sample
    logic [3:0]  gr_reg;
    logic        over_reg;
    logic        under_reg;
    wire  [23:0] mag      = i_sample[23] ? 24'(-i_sample) : 24'(i_sample);
    wire  [3:0]  thr_stp  = (thr >= `THR_ZERO_DB) ? 4'h0 : 4'(`THR_ZERO_DB - thr);
    wire  [23:0] thr_mag  = `FULL_SCALE >> thr_stp;
    wire  [23:0] lvl_now  = mag >> gr_reg;
    wire  [23:0] lvl_up   = mag >> (gr_reg - 4'h1);
    wire  [31:0] atk_step = ATTACK_UNIT_CYCLES << atr;
    wire  [31:0] rel_step = RELEASE_UNIT_CYCLES << rrt;
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            over_reg  <= 1'b0;
            under_reg <= 1'b0;
        end else if (i_sample_valid) begin
            over_reg  <= limiter_enable_bit & (lvl_now > thr_mag);
            under_reg <= (gr_reg != 4'h0) & (lvl_up <= thr_mag);
        end
    end

    // gain reduction: one step per attack or release period
    logic [31:0] atk_cnt_reg;
    logic [31:0] rel_cnt_reg;
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            gr_reg      <= 4'h0;
            atk_cnt_reg <= 32'h0;
            rel_cnt_reg <= 32'h0;
        end else if (!limiter_enable_bit) begin
            gr_reg      <= 4'h0;
            atk_cnt_reg <= 32'h0;
            rel_cnt_reg <= 32'h0;
        end else begin
            atk_cnt_reg <= (over_reg && atk_cnt_reg < atk_step - 32'h1) ? atk_cnt_reg + 32'h1 : 32'h0;
            rel_cnt_reg <= (under_reg && !over_reg && rel_cnt_reg < rel_step - 32'h1) ? rel_cnt_reg + 32'h1 : 32'h0;
            if (over_reg && atk_cnt_reg == atk_step - 32'h1 && gr_reg != `GR_MAX) begin
                gr_reg <= gr_reg + 4'h1;
            end else if (under_reg && !over_reg && rel_cnt_reg == rel_step - 32'h1 && gr_reg != 4'h0) begin
                gr_reg <= gr_reg - 4'h1;
            end
        end
    end

    // symmetric clipper after the limiter gain
    wire lcfs_pkg::sample_t lim_s  = i_sample >>> gr_reg;
    wire lcfs_pkg::sample_t clip_p = {1'b0, clip_reg, 15'h7FFF};
    wire lcfs_pkg::sample_t clip_n = -clip_p;
    wire                    hi_cl  = lim_s > clip_p;
    wire                    lo_cl  = lim_s < clip_n;
    wire lcfs_pkg::sample_t out_s  = hi_cl ? clip_p : (lo_cl ? clip_n : lim_s);
    wire                    clip_ev = i_sample_valid & (hi_cl | lo_cl);

    // sample output register
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_sample       <= 24'sh0;
            o_sample_valid <= 1'b0;
        end else begin
            o_sample_valid <= i_sample_valid;
            if (i_sample_valid) o_sample <= out_s;
        end
    end

    // sticky status: set wins over clear, warning bit is live
    wire [7:0] events  = {gr_reg != 4'h0, clip_ev, i_serial_err, i_clk_ratio_err,
                          uvlo_s, 1'b0, otf_s, ocp_s};
    wire [7:0] st_hold = (st_clr ? 8'h00 : status_reg) | events;
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= 8'h00;
        end else begin
            status_reg          <= st_hold;
            status_reg[`ST_OTW] <= otw_s;
        end
    end

    // power stage control, short latches drivers off until cleared
    wire ocp_en = amp_output_control_reg[`AMP_OCP_EN_BIT];
    wire drv_on = ~shdn & ~(ocp_en & (status_reg[`ST_OCP] | ocp_s));
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_drv_en       <= 1'b0;
            o_low_emi      <= 1'b0;
            o_load_setting <= 2'h0;
            o_low_power    <= 1'b0;
            o_sda_out      <= 1'b0;
            o_sda_oe       <= 1'b0;
        end else begin
            o_drv_en       <= drv_on;
            o_low_emi      <= amp_output_control_reg[`AMP_EMI_BIT];
            o_load_setting <= amp_output_control_reg[`AMP_LOAD_MSB:`AMP_LOAD_LSB];
            o_low_power    <= amp_output_control_reg[`AMP_LPM_BIT];
            o_sda_out      <= 1'b0;
            o_sda_oe       <= oe_reg;
        end
    end

    // modulator
    mod_if mif ();
    assign mif.sample  = o_sample;
    assign mif.en      = o_drv_en;
    assign mif.low_emi = o_low_emi;
    three_level_mod u_mod (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .m       (mif.mod)
    );
    assign o_out_pos = mif.pos;
    assign o_out_neg = mif.neg;
endmodule

// [rtl/lcfs_defs.svh]
// register map, field positions, reset values and timing counts
`ifndef LCFS_DEFS_SVH
`define LCFS_DEFS_SVH

// register offsets
`define REG_PWR_CTRL      8'h04
`define REG_CLIP          8'h0B
`define REG_AMP_CTRL      8'h0E
`define REG_LIM_CTRL      8'h0F
`define REG_LIM_THR       8'h10
`define REG_STAT_CLR      8'h12
`define REG_STATUS        8'h13
`define REG_MAX           8'h14

// reset values and writable masks
`define PWR_CTRL_RST      8'h01
`define PWR_CTRL_MASK     8'h13
`define CLIP_RST          8'hFF
`define AMP_CTRL_RST      8'h14
`define AMP_CTRL_MASK     8'h1F
`define LIM_CTRL_RST      8'h22
`define LIM_CTRL_MASK     8'h33
`define LIM_THR_RST       8'h0A
`define LIM_THR_MASK      8'h1F

// field positions
`define PWR_LIMITER_ENABLE_BIT_BIT    4
`define PWR_SHDN_BIT      0
`define AMP_OCP_EN_BIT    4
`define AMP_LOAD_MSB      3
`define AMP_LOAD_LSB      2
`define AMP_EMI_BIT       1
`define AMP_LPM_BIT       0
`define LIMITER_RELEASE_RATE_FIELD_MSB       5
`define LIMITER_RELEASE_RATE_FIELD_LSB       4
`define LIMITER_ATTACK_RATE_FIELD_MSB       1
`define LIMITER_ATTACK_RATE_FIELD_LSB       0
`define THR_MSB           4
`define THR_ZERO_DB       5'h0A
`define STAT_CLR_BIT      0
`define ST_OCP            0
`define ST_OTW            2

// two-wire address, upper five bits
`define I2C_ADDR_HI       5'h0D

// limiter timing: one gain step is 6 dB, rate base per field code 0
`define CLK_FREQ_MHZ      10
`define DB_PER_STEP       6
`define ATTACK_BASE_US    30
`define RELEASE_BASE_MS   400
`define ATTACK_UNIT_CYC   (`ATTACK_BASE_US * `DB_PER_STEP * `CLK_FREQ_MHZ)
`define RELEASE_UNIT_CYC  (`RELEASE_BASE_MS * 1000 * `DB_PER_STEP * `CLK_FREQ_MHZ)
`define GR_MAX            4'hF
`define FULL_SCALE        24'h7FFFFF

// modulator quantiser step and decision level
`define MOD_STEP          26'sh0800000
`define MOD_HALF          26'sh0400000

`endif

// [rtl/lcfs_pkg.sv]
// types shared by the limiter, clipper and status block
package lcfs_pkg;
    typedef logic signed [23:0] sample_t;
    typedef enum logic [3:0] {
        I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_SUB, I2C_SUB_ACK,
        I2C_WDATA, I2C_WACK, I2C_RDATA, I2C_RACK
    } i2c_state_t;
endpackage

// [rtl/mod_if.sv]
// sample and pulse signals between control logic and modulator
`timescale 1ns/1ps
interface mod_if;
    lcfs_pkg::sample_t sample;
    logic              en;
    logic              low_emi;
    logic              pos;
    logic              neg;
    modport src (output sample, en, low_emi, input pos, neg);
    modport mod (input sample, en, low_emi, output pos, neg);
endinterface

// [rtl/bit_sync.sv]
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module bit_sync #(
    parameter int                 WIDTH   = 1,
    parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage_reg;

    // first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage_reg <= RST_VAL;
            o_sync    <= RST_VAL;
        end else begin
            stage_reg <= i_async;
            o_sync    <= stage_reg;
        end
    end
endmodule

// [rtl/three_level_mod.sv]
// three-level sigma-delta pulse modulator
`timescale 1ns/1ps
`include "lcfs_defs.svh"
module three_level_mod (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    mod_if.mod        m
);
    logic signed [25:0] acc_reg;
    wire  signed [25:0] x_ext  = 26'(m.sample);
    // low emi: never swing straight from one rail pair to the other
    wire                blk_p  = m.low_emi & m.neg;
    wire                blk_n  = m.low_emi & m.pos;
    // polarity follows sign, density rises with level
    wire                go_p   = m.en & (acc_reg >= `MOD_HALF) & ~blk_p;
    wire                go_n   = m.en & (acc_reg < -`MOD_HALF) & ~blk_n;
    wire  signed [25:0] fb     = go_p ? `MOD_STEP : (go_n ? -`MOD_STEP : 26'sh0);
    wire  signed [25:0] acc_nx = acc_reg + x_ext - fb;

    // idle keeps both outputs mid rail, residue gives rare one-cycle pulses
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_reg <= 26'sh0;
            m.pos   <= 1'b0;
            m.neg   <= 1'b0;
        end else begin
            acc_reg <= m.en ? acc_nx : 26'sh0;
            m.pos   <= go_p;
            m.neg   <= go_n;
        end
    end
endmodule

// [sim/lcfs_properties.sv]
// port-level checks for the limiter, clipper and status block
`timescale 1ns/1ps
module lcfs_properties (
    input wire logic              i_clk,
    input wire logic              i_reset_n,
    input wire logic              i_sample_valid,
    input wire logic              i_short_det,
    input wire lcfs_pkg::sample_t o_sample,
    input wire logic              o_sample_valid,
    input wire logic              o_sda_out,
    input wire logic              o_out_pos,
    input wire logic              o_out_neg,
    input wire logic              o_drv_en
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // sample path, bus pin and power stage
    a_valid_follows: assert property (i_sample_valid |=> o_sample_valid) else $error("no valid");
    a_valid_cause: assert property (o_sample_valid |-> $past(i_sample_valid)) else $error("stray valid");
    a_sample_hold: assert property (!o_sample_valid |-> $stable(o_sample)) else $error("sample moved");
    a_pulse_excl: assert property (!(o_out_pos && o_out_neg)) else $error("both pulses");
    a_sda_never_high: assert property (!o_sda_out) else $error("sda driven high");
    a_short_drv_off: assert property (i_short_det [*2] |-> ##[0:5] !o_drv_en) else $error("drv on");
    a_idle_no_pulse: assert property (!o_drv_en [*3] |-> !o_out_pos && !o_out_neg) else $error("pulse");
    a_ocp_sticky: assert property ($fell(i_short_det) |-> ##4 !o_drv_en) else $error("ocp not held");
    c_sample: cover property (o_sample_valid);
    c_drv_off: cover property ($fell(o_drv_en));
    c_drv_on: cover property ($rose(o_drv_en));
endmodule
bind limiter_clipper_fault_status lcfs_properties chk_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_sample_valid(i_sample_valid), .i_short_det(i_short_det), .o_sample(o_sample),
    .o_sample_valid(o_sample_valid), .o_sda_out(o_sda_out), .o_out_pos(o_out_pos),
    .o_out_neg(o_out_neg), .o_drv_en(o_drv_en));

// [sim/i2c_master_model.sv]
// two-wire bus master model, 800 ns bit period
`timescale 1ns/1ps
module i2c_master_model #(parameter logic [6:0] ADDR = 7'h36) (
    output logic      o_scl,
    output logic      o_sda_low,
    input  wire logic i_sda
);
    logic a;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // one bus clock: data set in low phase, sampled mid high
    task bit9(input logic b, output logic s);
        #200 o_sda_low <= !b;
        #200 o_scl <= 1'b1;
        #200 s = i_sda;
        #200 o_scl <= 1'b0;
    endtask
    task xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit9(d[i], q[i]);
        end
        bit9(1'b1, a);
        ack = !a;
    endtask
    task start();
        #200 o_sda_low <= 1'b0;
        #200 o_scl <= 1'b1;
        #200 o_sda_low <= 1'b1;
        #200 o_scl <= 1'b0;
    endtask
    // write, or pointer then read; ok when all acks came
    task access(input logic [7:0] sub, d, input logic rd, output logic [7:0] q, output logic ok);
        logic [7:0] x;
        logic k1, k2, k3;
        start();
        xbyte({ADDR, 1'b0}, x, k1);
        xbyte(sub, x, k2);
        if (rd) begin
            start();
            xbyte({ADDR, 1'b1}, x, k3);
            xbyte(8'hFF, q, a);
        end else begin
            xbyte(d, x, k3);
        end
        #200 o_sda_low <= 1'b1;
        #200 o_scl <= 1'b1;
        #200 o_sda_low <= 1'b0;
        #400 ok = k1 & k2 & k3;
    endtask
endmodule

// [sim/limiter_clipper_fault_status_test.sv]
// self-checking bench for the limiter, clipper and status block
`timescale 1ns/1ps
module limiter_clipper_fault_status_test;
    logic              i_clk = 0, i_reset_n = 0, overtemp_warning_flag = 0, sv = 0, oe, scl, mlow, osv, drv, emi;
    logic [3:0]        flt = 0;
    logic [1:0]        load;
    lcfs_pkg::sample_t smp = 0, osmp;
    int                n_fail = 0, n_compared = 0;
    wire sda = !(oe | mlow);
    always #50 i_clk = !i_clk;
    i2c_master_model mdl (.o_scl(scl), .o_sda_low(mlow), .i_sda(sda));
    limiter_clipper_fault_status #(.ATTACK_UNIT_CYCLES(32'h4), .RELEASE_UNIT_CYCLES(32'h8)) uut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_scl(scl), .i_sda_in(sda), .o_sda_out(), .o_sda_oe(oe),
        .i_addr_sel(2'h2), .i_sample(smp), .i_sample_valid(sv), .i_short_det(flt[0]), .i_overtemp(flt[1]),
        .i_overtemp_warn(overtemp_warning_flag), .i_undervolt(flt[2]), .i_clk_ratio_err(flt[3]), .i_serial_err(flt[3]),
        .o_sample(osmp), .o_sample_valid(osv), .o_out_pos(), .o_out_neg(), .o_drv_en(drv), .o_low_emi(emi),
        .o_load_setting(load), .o_low_power());
    task chk(input logic [23:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task final_report();
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // register read over the bus, ack folded in as bit 8
    task rd(input logic [7:0] sub, output logic [23:0] v);
        logic [7:0] q;
        logic ok;
        mdl.access(sub, 8'h00, 1'b1, q, ok);
        v = {15'h0, ok, q};
    endtask
    task wr(input logic [7:0] sub, d);
        logic [7:0] q;
        logic ok;
        mdl.access(sub, d, 1'b0, q, ok);
        chk({23'h0, ok}, 24'h1);
        repeat (4) @(posedge i_clk);
    endtask
    task send(input lcfs_pkg::sample_t s);
        @(posedge i_clk);
        smp <= s;
        sv <= 1'b1;
        @(posedge i_clk);
        sv <= 1'b0;
        repeat (3) @(negedge i_clk);
    endtask
    task t_controls();
        logic [23:0] v;
        rd(8'h0E, v);
        chk(v, 24'h114);
        rd(8'h10, v);
        chk(v, 24'h10A);
        chk({23'h0, drv}, 24'h0);
        wr(8'h0E, 8'h1A);
        chk({21'h0, load, emi}, 24'h5);
        wr(8'h04, 8'h00);
        chk({23'h0, drv}, 24'h1);
    endtask
    task t_clip();
        logic [23:0] v;
        send(24'h7FFFFF);
        chk(osmp, 24'h7FFFFF);
        wr(8'h10, 8'h09);
        wr(8'h04, 8'h10);
        send(24'h600000);
        repeat (16) @(posedge i_clk);
        send(24'h100000);
        chk(osmp, 24'h080000);
        repeat (40) @(posedge i_clk);
        send(24'h100000);
        chk(osmp, 24'h100000);
        wr(8'h04, 8'h00);
        wr(8'h0B, 8'h3F);
        send(24'h400000);
        chk(osmp, 24'h1FFFFF);
        send(24'hC00000);
        chk(osmp, 24'hE00001);
        rd(8'h13, v);
        chk(v, 24'h1C0);
    endtask
    task t_faults();
        logic [23:0] v;
        flt <= 4'hF;
        overtemp_warning_flag <= 1'b1;
        repeat (6) @(posedge i_clk);
        flt <= 4'h0;
        repeat (6) @(posedge i_clk);
        chk({23'h0, drv}, 24'h0);
        rd(8'h13, v);
        chk(v, 24'h1FF);
        wr(8'h12, 8'h01);
        rd(8'h13, v);
        chk(v, 24'h104);
        overtemp_warning_flag <= 1'b0;
        repeat (4) @(posedge i_clk);
        rd(8'h13, v);
        chk(v, 24'h100);
        chk({23'h0, drv}, 24'h1);
    endtask
    initial begin
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (10) @(posedge i_clk);
        t_controls();
        t_clip();
        t_faults();
        final_report();
    end
    initial begin
        #3000000;
        n_fail++;
        final_report();
    end
endmodule
